//--- rtl/pdr_pkg.sv
// How it works
// - format code picks BCD unit or binary
// - code 6 five-digit BCD, wide card only
// - display unit two or more forces BCD
// - display unit two or more sets stored reference units
// - unit 0 hertz, 1 percent, 2-39 rpm
// - 40 to 39999 user scale, low digits
// - leading digit gives decimal places
// - width switch with format picks 12/16 bits
// - binary weights upward; BCD nibbles lsd first
package pdr_pkg;
  localparam logic [7:0]  ADDR_FORMAT  = 8'h00;
  localparam logic [7:0]  ADDR_UNIT    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS  = 8'h08;
  localparam logic [7:0]  ADDR_REF     = 8'h0c;
  localparam logic [7:0]  ADDR_UNITOUT = 8'h10;
  localparam logic [2:0]  FORMAT_RST   = 3'h0;
  localparam logic [15:0] UNIT_RST     = 16'h0000;
  localparam logic [2:0]  FMT_BINARY   = 3'h7;
  localparam logic [2:0]  FMT_BCD5     = 3'h6;
  localparam logic [15:0] UNIT_MAX     = 16'h9c3f;
  localparam logic [15:0] UNIT_RPM_LO  = 16'h0002;
  localparam logic [15:0] UNIT_USER_LO = 16'h0028;

  typedef enum logic [2:0] {
    PDR_U_PCT1    = 3'b000,
    PDR_U_PCT01   = 3'b001,
    PDR_U_HZ1     = 3'b010,
    PDR_U_HZ01    = 3'b011,
    PDR_U_HZ001   = 3'b100,
    PDR_U_BINARY  = 3'b101,
    PDR_U_DISPLAY = 3'b110
  } pdr_ref_unit_t;

  typedef enum logic [1:0] {
    PDR_D_HZ   = 2'b00,
    PDR_D_PCT  = 2'b01,
    PDR_D_RPM  = 2'b10,
    PDR_D_USER = 2'b11
  } pdr_disp_kind_t;

  typedef struct packed {
    logic [15:0] data;
    logic        sign;
    logic        strobe;
  } pdr_pins_t;

  typedef struct packed {
    logic [31:0]    magnitude;
    logic           negative;
    pdr_ref_unit_t  ref_unit;
    pdr_disp_kind_t disp_kind;
    logic [5:0]     poles;
    logic [13:0]    user_full;
    logic [2:0]     user_dp;
  } pdr_ref_t;
endpackage : pdr_pkg

//--- rtl/pdr_decoder.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pdr_decoder (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  // terminal pins and card switch
  input  wire logic [15:0]   ref_data_pins,
  input  wire logic          ref_sign_pin,
  input  wire logic          ref_strobe_pin,
  input  wire logic          input_width_switch,
  // drive state
  input  wire logic          drive_running,
  // decoded reference
  output var  pdr_pkg::pdr_ref_t ref_out,
  output var  logic          ref_valid
);
  import pdr_pkg::*;

  // pin synchronisers and card switch
  pdr_pins_t   pins_meta;
  pdr_pins_t   pins_sync;
  logic [1:0]  wide_sync;
  logic        is_wide;

  // settings held by software
  logic [2:0]  reference_format_select;
  logic [15:0] display_unit_select;

  // captured reference word
  logic [15:0] word_latched;
  logic        sign_latched;
  logic        captured;

  // address match, shared by every register
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] b);
    return a == b;
  endfunction : addr_is

  // display-unit value at or above a bound
  function automatic logic unit_at_least(input logic [15:0] u,
                                         input logic [15:0] b);
    return u >= b;
  endfunction : unit_at_least

  // two flip-flops on every pin before any logic reads it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_meta <= '0;
    end else begin
      pins_meta <= '{ref_data_pins, ref_sign_pin, ref_strobe_pin};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_sync <= '0;
    end else begin
      pins_sync <= pins_meta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wide_sync <= 2'b00;
    end else begin
      wide_sync <= {wide_sync[0], input_width_switch};
    end
  end

  assign is_wide = wide_sync[1];

  // apb phases
  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable;
  wire apb_first  = apb_access & ~pready;
  wire apb_done   = apb_access & pready;

  // address decode
  wire hit_fmt  = addr_is(paddr, ADDR_FORMAT);
  wire hit_unit = addr_is(paddr, ADDR_UNIT);
  wire hit_stat = addr_is(paddr, ADDR_STATUS);
  wire hit_ref  = addr_is(paddr, ADDR_REF);
  wire hit_uout = addr_is(paddr, ADDR_UNITOUT);
  wire hit_ro   = hit_stat | hit_ref | hit_uout;
  wire mapped   = hit_fmt | hit_unit | hit_ro;

  // out-of-range or locked writes are refused
  wire [15:0] wr_unit  = pwdata[15:0];
  wire        unit_hi0 = pwdata[31:16] == 16'h0000;
  wire        unit_ok  = unit_hi0 && (wr_unit <= UNIT_MAX);
  wire        fmt_ok   = pwdata[31:3] == 29'h0;
  wire        locked   = drive_running;
  wire wr_fmt_bad  = hit_fmt & (~fmt_ok | locked);
  wire wr_unit_bad = hit_unit & (~unit_ok | locked);
  wire wr_err      = ~mapped | wr_fmt_bad |
                     wr_unit_bad | hit_ro;
  wire rd_err      = ~mapped;
  wire any_err     = pwrite ? wr_err : rd_err;

  // a write lands at the edge where pready is sampled high
  wire        wr_land       = apb_done & pwrite;
  wire        fmt_take      = wr_land & hit_fmt & ~wr_fmt_bad;
  wire        unit_take     = wr_land & hit_unit & ~wr_unit_bad;
  wire [2:0]  next_format   = fmt_take ? pwdata[2:0] :
                              reference_format_select;
  wire [15:0] next_unit_sel = unit_take ? wr_unit : display_unit_select;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reference_format_select <= FORMAT_RST;
    end else begin
      reference_format_select <= next_format;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      display_unit_select <= UNIT_RST;
    end else begin
      display_unit_select <= next_unit_sel;
    end
  end

  // capture while the synced strobe is high
  wire next_captured = captured | pins_sync.strobe;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_latched <= 16'h0000;
    end else if (pins_sync.strobe) begin
      word_latched <= pins_sync.data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sign_latched <= 1'b0;
    end else if (pins_sync.strobe) begin
      sign_latched <= pins_sync.sign;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      captured <= 1'b0;
    end else begin
      captured <= next_captured;
    end
  end

  // format interpretation
  wire force_bcd = unit_at_least(display_unit_select, UNIT_RPM_LO);
  wire is_fmt6   = reference_format_select == FMT_BCD5;
  wire fmt_bcd5  = is_fmt6 & is_wide;
  wire is_fmt7   = reference_format_select == FMT_BINARY;
  wire fmt_bin   = is_fmt7 & ~force_bcd;
  wire [2:0] n_digits = fmt_bcd5 ? 3'd5 : (is_wide ? 3'd4 : 3'd3);

  // five-digit mode uses the sign line as the top data bit
  wire [19:0] bcd_word = fmt_bcd5 ?
      {3'b000, sign_latched, word_latched} : {4'h0, word_latched};
  wire [15:0] bin_word = is_wide ? word_latched :
      {4'h0, word_latched[11:0]};

  // one stage per digit, most significant first; unused digits pass
  wire [31:0] bcd_stage [6];
  assign bcd_stage[0] = 32'h0000_0000;
  for (genvar g = 0; g < 5; g++) begin : g_bcd
    localparam int D = 4 - g;
    wire [3:0]  digit  = bcd_word[D*4 +: 4];
    wire        in_use = 3'(D) < n_digits;
    wire [31:0] scaled = 32'(bcd_stage[g] * 32'd10);
    wire [31:0] summed = 32'(scaled + {28'h0, digit});
    assign bcd_stage[g+1] = in_use ? summed : bcd_stage[g];
  end
  // sign and magnitude
  wire [31:0] bcd_mag  = bcd_stage[5];
  wire [31:0] next_mag = fmt_bin ? {16'h0000, bin_word} : bcd_mag;
  wire        next_neg = ~fmt_bcd5 & sign_latched;

  pdr_ref_unit_t next_unit;
  always_comb begin
    // codes 1 and 2 share one unit
    unique case (reference_format_select)
      3'h0: next_unit = PDR_U_PCT1;
      3'h1: next_unit = PDR_U_PCT01;
      3'h2: next_unit = PDR_U_PCT01;
      3'h3: next_unit = PDR_U_HZ1;
      3'h4: next_unit = PDR_U_HZ01;
      3'h5: next_unit = PDR_U_HZ001;
      3'h6: next_unit = is_wide ? PDR_U_HZ001 : PDR_U_HZ01;
      3'h7: next_unit = PDR_U_BINARY;
    endcase
    if (force_bcd) begin
      next_unit = PDR_U_DISPLAY;
    end
  end

  // display unit decode
  wire [15:0] du        = display_unit_select;
  wire [15:0] user_lead = 16'(du / 16'd10000);
  wire [15:0] user_low  = 16'(du % 16'd10000);
  wire        is_hz     = du == 16'h0000;
  wire        is_pct    = du == 16'h0001;
  wire        is_user   = unit_at_least(du, UNIT_USER_LO);
  wire        is_rpm    = ~is_hz & ~is_pct & ~is_user;
  pdr_disp_kind_t next_kind;
  assign next_kind = is_hz  ? PDR_D_HZ  :
                     is_pct ? PDR_D_PCT :
                     is_rpm ? PDR_D_RPM : PDR_D_USER;
  wire [5:0]  next_poles = is_rpm ?
      du[5:0] : 6'h00;
  wire [13:0] next_full  = is_user ?
      user_low[13:0] : 14'h0000;
  wire [2:0]  next_dp    = is_user ?
      user_lead[2:0] : 3'h0;

  // one unit setting governs stored reference and monitors
  pdr_ref_t next_ref;
  assign next_ref = '{next_mag, next_neg, next_unit, next_kind,
                      next_poles, next_full, next_dp};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_out <= '0;
    end else begin
      ref_out <= next_ref;
    end
  end

  // valid from the first capture on
  wire next_valid = captured;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_valid <= 1'b0;
    end else begin
      ref_valid <= next_valid;
    end
  end

  // read words
  wire [4:0]  stat_bits = {force_bcd, fmt_bin, is_wide,
                           locked, captured};
  wire [31:0] stat_word = {27'h0, stat_bits};
  wire [31:0] ref_word  = {ref_out.negative, ref_out.magnitude[30:0]};
  wire [31:0] uout_word = {3'h0, ref_out.ref_unit, ref_out.disp_kind,
                           ref_out.poles, ref_out.user_full, 1'b0,
                           ref_out.user_dp};
  wire [31:0] fmt_word  = {29'h0, reference_format_select};
  wire [31:0] unit_word = {16'h0000, display_unit_select};

  wire [31:0] rd_mux =
      hit_fmt  ? fmt_word  :
      hit_unit ? unit_word :
      hit_stat ? stat_word :
      hit_ref  ? ref_word  :
      hit_uout ? uout_word : 32'h0000_0000;

  // one wait state: answer in the second access cycle
  wire        next_pready  = apb_first;
  wire        next_pslverr = apb_first & any_err;
  wire [31:0] next_prdata  = (apb_first & ~pwrite) ? rd_mux : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= next_pready;
    end
  end

  // a refused write leaves the stored settings untouched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  wire unused_ok = apb_setup;
endmodule : pdr_decoder
`default_nettype wire

//--- dv/pdr_props.sv
`timescale 1ns/100ps
`default_nettype none
module pdr_props (
  // apb side
  input wire logic clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // pins and reference
  input wire logic [15:0] ref_data_pins,
  input wire logic ref_sign_pin, ref_strobe_pin, input_width_switch,
  input wire logic drive_running, ref_valid,
  input wire pdr_pkg::pdr_ref_t ref_out
);
  import pdr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr = psel && penable && pready && pwrite;
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  property p_wait; s_setup |=> s_answer; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_rdz; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("data outside answer");
  property p_lock; wr && drive_running |-> pslverr; endproperty
  a_lock: assert property (p_lock) else $error("write while running");
  property p_range;
    wr && ((paddr == ADDR_FORMAT && pwdata[31:3] != 0) ||
           (paddr == ADDR_UNIT && pwdata > UNIT_MAX)) |-> pslverr;
  endproperty
  a_range: assert property (p_range) else $error("range accepted");
  property p_valid; ref_valid |=> ref_valid; endproperty
  a_valid: assert property (p_valid) else $error("valid dropped");
  property p_cap; $rose(ref_strobe_pin) |-> ##[1:6] ref_valid; endproperty
  a_cap: assert property (p_cap) else $error("no capture");
  property p_force;
    ref_out.ref_unit == PDR_U_DISPLAY |-> ref_out.disp_kind[1];
  endproperty
  a_force: assert property (p_force) else $error("bad forced unit");
  property p_user;
    ref_out.disp_kind == PDR_D_USER |->
      ref_out.user_dp <= 3 && ref_out.user_full < 14'd10000;
  endproperty
  a_user: assert property (p_user) else $error("bad user scale");
endmodule : pdr_props
`default_nettype wire

//--- dv/pdr_pins_drv.sv
`timescale 1ns/100ps
`default_nettype none
module pdr_pins_drv (
  input  wire logic        clk,
  input  wire logic [15:0] word,
  input  wire logic        sgn,
  input  wire logic        go,
  output var  pdr_pkg::pdr_pins_t pins
);
  logic [1:0] held = 2'h0;
  initial pins = '0;
  // word holds three cycles past the strobe, then churns
  always @(posedge clk) begin
    if (go) begin
      pins <= '{data: word, sign: sgn, strobe: 1'b1};
      held <= 2'h0;
    end else if (held != 2'h3) begin
      pins.strobe <= 1'b0;
      held <= held + 2'h1;
    end else
      pins <= '{data: ~pins.data, sign: ~pins.sign, strobe: 1'b0};
  end
endmodule : pdr_pins_drv
`default_nettype wire

//--- dv/pdr_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
module pdr_decoder_test;
  import pdr_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, serr;
  logic wide = 1, run = 0, go = 0, sgn = 0, pready, pslverr, vld;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic [15:0] word = 16'h0000;
  logic [15:0] uv [6] = '{0, 1, 3, 12000, 39999, 40};
  logic [1:0]  dk [6] = '{0, 1, 2, 3, 3, 3};
  pdr_ref_t    ro;
  pdr_pins_t   pins;
  int failures = 0, n_checks = 0;
  always #4 clk = ~clk;
  pdr_pins_drv drv (.clk(clk), .word(word), .sgn(sgn), .go(go), .pins(pins));
  pdr_decoder dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_data_pins(pins.data),
    .ref_sign_pin(pins.sign), .ref_strobe_pin(pins.strobe),
    .input_width_switch(wide), .drive_running(run), .ref_out(ro),
    .ref_valid(vld));
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc
  task automatic cap(input logic [15:0] w, input logic s);
    @(posedge clk);
    word <= w;
    sgn <= s;
    go <= 1'b1;
    repeat (4) @(posedge clk);
    go <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : cap
  task automatic er(input logic [31:0] m, input logic n, input logic [2:0] u);
    chk(ro.magnitude, m);
    chk(ro.negative, n);
    chk(ro.ref_unit, u);
  endtask : er
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    failures++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    acc(0, ADDR_FORMAT, 0); chk(rdat, 0);
    acc(0, ADDR_UNIT, 0); chk(rdat, 0);
    acc(1, ADDR_FORMAT, FMT_BINARY); chk(serr, 0);
    wide <= 1'b0;
    cap(16'hf123, 1); er(32'h0000_0123, 1, PDR_U_BINARY);
    chk(vld, 1);
    wide <= 1'b1;
    cap(16'hf123, 0); er(32'h0000_f123, 0, PDR_U_BINARY);
    for (int f = 0; f < 6; f++) begin
      acc(1, ADDR_FORMAT, f);
      cap(16'h1234, 1); er(1234, 1, 3'(f < 2 ? f : f - 1));
    end
    wide <= 1'b0;
    cap(16'h1234, 0); er(234, 0, PDR_U_HZ001);
    acc(1, ADDR_FORMAT, FMT_BCD5);
    cap(16'h1234, 1); er(234, 1, PDR_U_HZ01);
    wide <= 1'b1;
    cap(16'h1234, 1); er(11234, 0, PDR_U_HZ001);
    repeat (12) @(posedge clk);
    er(11234, 0, PDR_U_HZ001);
    acc(0, ADDR_REF, 0); chk(rdat, 11234);
    acc(0, ADDR_STATUS, 0); chk(rdat, 32'h0000_0005);
    acc(1, ADDR_FORMAT, FMT_BINARY);
    for (int i = 0; i < 6; i++) begin
      acc(1, ADDR_UNIT, uv[i]);
      cap(16'h0042, 0);
      chk(ro.magnitude, i < 2 ? 32'h0000_0042 : 42);
      chk(ro.ref_unit, i < 2 ? PDR_U_BINARY : PDR_U_DISPLAY);
      chk(ro.disp_kind, dk[i]);
      if (i == 2) chk(ro.poles, 3);
      if (i > 2) chk(ro.user_full, uv[i] % 10000);
      if (i > 2) chk(ro.user_dp, uv[i] / 10000);
    end
    acc(1, ADDR_UNIT, 32'h0000_9c40); chk(serr, 1);
    acc(0, ADDR_UNIT, 0); chk(rdat, 40);
    acc(1, ADDR_FORMAT, 32'h0000_0008); chk(serr, 1);
    run <= 1'b1;
    acc(1, ADDR_FORMAT, 0); chk(serr, 1);
    acc(0, ADDR_FORMAT, 0); chk(rdat, 7);
    run <= 1'b0;
    acc(1, ADDR_STATUS, 0); chk(serr, 1);
    acc(0, 8'h20, 0); chk(serr, 1);
    end_sim;
  end
endmodule : pdr_decoder_test
bind pdr_decoder pdr_props chk_i (.*);
`default_nettype wire
